/* dv/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  import usb_rx_status_pkg::*;
  logic mclk, rst_n, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] ev_ep;
  logic tok_valid, out_ack_sent, setup_hs_start, setup_hs_end, rx_end, rx_ok;
  token_kind_t tok_kind;
  logic [15:0] ep_ctrl, ep_rx_en, rx_stall_bit, tx_stall_bit, rx_fifo_full, rx_fifo_err;
  logic resp_valid, resp_nak, resp_stall;
  logic [15:0] rx_data_toggle, setup_received_flag, rx_fifo_lock, rx_fifo_clear;
  int err_total;
  int check_count;
  int i;

  usb_rx_endpoint_status uut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_ep(ev_ep),
    .tok_valid(tok_valid), .tok_kind(tok_kind), .out_ack_sent(out_ack_sent),
    .setup_hs_start(setup_hs_start), .setup_hs_end(setup_hs_end), .rx_end(rx_end),
    .rx_ok(rx_ok), .ep_ctrl(ep_ctrl), .ep_rx_en(ep_rx_en), .rx_stall_bit(rx_stall_bit),
    .tx_stall_bit(tx_stall_bit), .rx_fifo_full(rx_fifo_full), .rx_fifo_err(rx_fifo_err),
    .resp_valid(resp_valid), .resp_nak(resp_nak), .resp_stall(resp_stall),
    .rx_data_toggle(rx_data_toggle), .setup_received_flag(setup_received_flag),
    .rx_fifo_lock(rx_fifo_lock), .rx_fifo_clear(rx_fifo_clear)
  );

  usb_host_model host (
    .mclk(mclk), .ev_ep(ev_ep), .tok_valid(tok_valid), .tok_kind(tok_kind),
    .out_ack_sent(out_ack_sent), .setup_hs_start(setup_hs_start),
    .setup_hs_end(setup_hs_end), .rx_end(rx_end), .rx_ok(rx_ok)
  );

  // ---------------------------------------------------------------
  // clock, checks and bus tasks
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic finish_test;
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic tok(input logic [3:0] e, input token_kind_t t, input logic [2:0] x);
    host.ev(0, e, t, 1'b1);
    #1;
    chk({5'h0, resp_valid, resp_nak, resp_stall}, {5'h0, x});
  endtask

  initial begin
    #(50 * 3000);
    err_total++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    err_total = 0;
    check_count = 0;
    rst_n = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    ep_ctrl = 16'h0003;
    ep_rx_en = 16'hffff;
    {rx_stall_bit, tx_stall_bit, rx_fifo_full, rx_fifo_err} = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h0d, 8'h00);
    rd(8'h33, 8'h00);
    wr(8'h33, 8'hff);
    rd(8'h0d, 8'h00);
    wr(8'h0f, 8'h01);
    tok(4'h1, TOK_OUT, 3'b100);
    host.ev(4, 4'h1, TOK_NONE, 1'b1);
    host.ev(1, 4'h1, TOK_NONE, 1'b1);
    rd(8'h0d, 8'h81);
    host.ev(1, 4'h1, TOK_NONE, 1'b1);
    rd(8'h0d, 8'h01);
    wr(8'h0d, 8'h80);
    rd(8'h0d, 8'h01);
    wr(8'h0d, 8'h88);
    rd(8'h0d, 8'h81);
    wr(8'h0d, 8'h27);
    rd(8'h0d, 8'h81);
    host.ev(4, 4'h1, TOK_NONE, 1'b0);
    wr(8'h0d, 8'h08);
    rd(8'h0d, 8'h02);
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      rx_stall_bit <= (i == 0) ? 16'h0002 : 16'h0000;
      ep_rx_en <= (i == 1) ? 16'hfffd : 16'hffff;
      rx_fifo_full <= (i == 2) ? 16'h0002 : 16'h0000;
      rx_fifo_err <= (i == 3) ? 16'h0002 : 16'h0000;
      tok(4'h1, TOK_OUT, (i == 0) ? 3'b101 : 3'b110);
      rd(8'h0d, 8'h06);
    end
    @(posedge mclk);
    rx_fifo_err <= 16'h0000;
    tok(4'h1, TOK_OUT, 3'b100);
    rd(8'h0d, 8'h02);
    @(posedge mclk);
    rx_stall_bit <= 16'h0002;
    tx_stall_bit <= 16'h0002;
    tok(4'h1, TOK_IN, 3'b101);
    host.ev(0, 4'h1, TOK_SETUP, 1'b1);
    #1;
    chk({4'h0, rx_fifo_clear[1], rx_fifo_lock[1], setup_received_flag[1], resp_valid},
        8'h0e);
    chk({7'h0, rx_data_toggle[1]}, 8'h01);
    @(posedge mclk);
    #1;
    chk({7'h0, rx_fifo_clear[1]}, 8'h00);
    rd(8'h0d, 8'he2);
    tok(4'h1, TOK_IN, 3'b110);
    tok(4'h1, TOK_OUT, 3'b110);
    host.ev(2, 4'h1, TOK_NONE, 1'b1);
    rd(8'h0d, 8'hf6);
    host.ev(3, 4'h1, TOK_NONE, 1'b1);
    rd(8'h0d, 8'hd6);
    chk({7'h0, rx_fifo_lock[1]}, 8'h01);
    @(posedge mclk);
    rx_stall_bit <= 16'h0000;
    tx_stall_bit <= 16'h0000;
    wr(8'h0d, 8'h00);
    rd(8'h0d, 8'h86);
    chk({7'h0, rx_fifo_lock[1]}, 8'h00);
    tok(4'h1, TOK_OUT, 3'b100);
    host.ev(0, 4'h2, TOK_SETUP, 1'b1);
    #1;
    chk({4'h0, rx_fifo_clear[2], rx_fifo_lock[2], setup_received_flag[2], rx_data_toggle[2]},
        8'h03);
    wr(8'h0f, 8'h02);
    rd(8'h0d, 8'hc0);
    rd(8'h0f, 8'h02);
    finish_test();
  end
endmodule

/* dv/usb_host_model.sv */
`timescale 1ns/1ps

module usb_host_model
  import usb_rx_status_pkg::*;
#(
  parameter int EP_W = 4
)
(
  input wire logic mclk,
  output logic [EP_W-1:0] ev_ep,
  output logic tok_valid,
  output token_kind_t tok_kind,
  output logic out_ack_sent,
  output logic setup_hs_start,
  output logic setup_hs_end,
  output logic rx_end,
  output logic rx_ok
);
  // ---------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------
  initial begin
    ev_ep = '0;
    tok_valid = 1'b0;
    tok_kind = TOK_NONE;
    out_ack_sent = 1'b0;
    setup_hs_start = 1'b0;
    setup_hs_end = 1'b0;
    rx_end = 1'b0;
    rx_ok = 1'b0;
  end

  // ---------------------------------------------------------------
  // one bus event: 0 token, 1 ack sent, 2 hs start, 3 hs end, 4 rx end
  // ---------------------------------------------------------------
  task automatic ev(input int k, input logic [EP_W-1:0] e, input token_kind_t t,
                    input logic ok);
    @(posedge mclk);
    ev_ep <= e;
    tok_kind <= t;
    rx_ok <= ok;
    case (k)
      0: tok_valid <= 1'b1;
      1: out_ack_sent <= 1'b1;
      2: setup_hs_start <= 1'b1;
      3: setup_hs_end <= 1'b1;
      default: rx_end <= 1'b1;
    endcase
    @(posedge mclk);
    {tok_valid, out_ack_sent, setup_hs_start, setup_hs_end, rx_end} <= '0;
    ev_ep <= ~e;
    rx_ok <= ~ok;
    tok_kind <= TOK_NONE;
  endtask
endmodule

/* rtl/rx_ep_status_cell.sv */
`timescale 1ns/1ps
`include "usb_rx_status_defs.svh"

module rx_ep_status_cell
  import usb_rx_status_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic is_ctrl,
  input wire logic ev_setup,
  input wire logic ev_out_ack,
  input wire logic ev_hs_start,
  input wire logic ev_hs_end,
  input wire logic ev_rx_end,
  input wire logic rx_ok,
  input wire logic ev_void_upd,
  input wire logic void_val,
  input wire logic fw_wr,
  input wire logic [7:0] fw_wdata,
  output logic [7:0] status,
  output logic fifo_lock,
  output logic fifo_clear
);

  ep_state_t st_reg;
  ep_state_t st_next;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.clear = 1'b0;
    if (fw_wr) begin
      if (fw_wdata[`ST_OVW_EN_BIT]) begin
        st_next.toggle = fw_wdata[`ST_TOGGLE_BIT];
      end
      st_next.setup = fw_wdata[`ST_SETUP_BIT];
      st_next.end_ovw = fw_wdata[`ST_END_OVW_BIT];
    end
    if (ev_out_ack) begin
      st_next.toggle = ~st_reg.toggle;
    end
    if (ev_setup) begin
      st_next.toggle = `TOGGLE_AFTER_SETUP;
      st_next.setup = 1'b1;
      if (is_ctrl) begin
        st_next.start_ovw = 1'b1;
        st_next.clear = 1'b1;
      end
    end
    if (ev_hs_start && is_ctrl) begin
      st_next.end_ovw = 1'b1;
    end
    if (ev_hs_end) begin
      st_next.start_ovw = 1'b0;
    end
    if (ev_rx_end) begin
      st_next.ack = rx_ok;
      st_next.err = ~rx_ok;
    end
    if (ev_void_upd) begin
      st_next.void_f = void_val;
    end
    st_next.lock = st_next.start_ovw | st_next.end_ovw;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // read view, enable bit reads zero
  // ---------------------------------------------------------------
  assign status = {st_reg.toggle, st_reg.setup, st_reg.start_ovw, st_reg.end_ovw,
                   1'b0, st_reg.void_f, st_reg.err, st_reg.ack};
  assign fifo_lock = st_reg.lock;
  assign fifo_clear = st_reg.clear;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_toggle_on_ack: assert property (ev_out_ack && !ev_setup |=>
    status[`ST_TOGGLE_BIT] != $past(status[`ST_TOGGLE_BIT]))
    else $error("toggle did not invert on out ack");
  a_toggle_needs_en: assert property (fw_wr && !fw_wdata[`ST_OVW_EN_BIT] &&
    !ev_out_ack && !ev_setup |=> $stable(status[`ST_TOGGLE_BIT]))
    else $error("toggle changed without overwrite enable");
  a_hs_sets_end: assert property (ev_hs_start && is_ctrl |=>
    status[`ST_END_OVW_BIT] && fifo_lock)
    else $error("end overwrite not set in handshake");
  a_ack_err_pair: assert property (ev_rx_end |=>
    status[`ST_ACK_BIT] == $past(rx_ok) && status[`ST_ERR_BIT] == !$past(rx_ok))
    else $error("ack and error not updated together");
  a_reset_reads_zero: assert property (@(posedge mclk) disable iff (1'b0)
    !rst_n |=> status == `RX_STATUS_RESET && !fifo_lock)
    else $error("status not zero after reset");

endmodule

/* rtl/usb_rx_endpoint_status.sv */
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "usb_rx_status_defs.svh"

// Notes on behaviour
// - acked OUT inverts receive toggle
// - SETUP token forces toggle to fixed value
// - toggle write needs enable bit same write
// - enable bit write-only, reads zero
// - valid SETUP sets setup-received flag
// - setup flag NAKs IN and OUT
// - setup NAK beats stall answer
// - control SETUP sets start-overwrite flag
// - start-overwrite resets and holds fifo state
// - setup handshake end clears start-overwrite
// - setup handshake sets end-overwrite on control
// - end-overwrite keeps fifo state frozen
// - status at 0x0d, indexed by endpoint
// - error and ack updated together
// - void records NAK or STALL to OUT
module usb_rx_endpoint_status
  import usb_rx_status_pkg::*;
#(
  parameter int NUM_EP = 16,
  parameter int EP_W = 4
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [EP_W-1:0] ev_ep,
  input wire logic tok_valid,
  input wire token_kind_t tok_kind,
  input wire logic out_ack_sent,
  input wire logic setup_hs_start,
  input wire logic setup_hs_end,
  input wire logic rx_end,
  input wire logic rx_ok,
  input wire logic [NUM_EP-1:0] ep_ctrl,
  input wire logic [NUM_EP-1:0] ep_rx_en,
  input wire logic [NUM_EP-1:0] rx_stall_bit,
  input wire logic [NUM_EP-1:0] tx_stall_bit,
  input wire logic [NUM_EP-1:0] rx_fifo_full,
  input wire logic [NUM_EP-1:0] rx_fifo_err,
  output logic resp_valid,
  output logic resp_nak,
  output logic resp_stall,
  output logic [NUM_EP-1:0] rx_data_toggle,
  output logic [NUM_EP-1:0] setup_received_flag,
  output logic [NUM_EP-1:0] rx_fifo_lock,
  output logic [NUM_EP-1:0] rx_fifo_clear
);

  // ---------------------------------------------------------------
  // top state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [EP_W-1:0] idx;
    logic [7:0] rdata;
    logic resp_valid;
    logic resp_nak;
    logic resp_stall;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;

  logic [NUM_EP-1:0] ep_hit;
  logic [NUM_EP-1:0] fw_hit;
  logic [NUM_EP-1:0] void_upd;
  logic [7:0] status_bus [NUM_EP];
  logic [7:0] cur_status;
  logic status_wr;
  logic is_in_out;
  logic is_out;
  logic stalled;
  logic hold_nak;
  logic out_refused;
  logic dec_nak;
  logic dec_stall;

  // ---------------------------------------------------------------
  // endpoint decode
  // ---------------------------------------------------------------
  always_comb begin
    ep_hit = '0;
    ep_hit[ev_ep] = 1'b1;
  end

  assign status_wr = reg_wr && (reg_addr == `ENDPOINT_RX_STATUS_ADDR);

  always_comb begin
    fw_hit = '0;
    fw_hit[st_reg.idx] = status_wr;
  end

  assign cur_status = status_bus[st_reg.idx];

  // ---------------------------------------------------------------
  // handshake decision
  // ---------------------------------------------------------------
  assign is_in_out = tok_valid && (tok_kind == TOK_IN || tok_kind == TOK_OUT);
  assign is_out = tok_valid && (tok_kind == TOK_OUT);
  assign hold_nak = setup_received_flag[ev_ep];
  assign stalled = (tok_kind == TOK_IN) ? tx_stall_bit[ev_ep] : rx_stall_bit[ev_ep];
  assign out_refused = (tok_kind == TOK_OUT) &&
                       (!ep_rx_en[ev_ep] || rx_fifo_full[ev_ep] || rx_fifo_err[ev_ep]);

  always_comb begin
    dec_nak = 1'b0;
    dec_stall = 1'b0;
    if (hold_nak) begin
      dec_nak = 1'b1;
    end else if (stalled) begin
      dec_stall = 1'b1;
    end else if (out_refused) begin
      dec_nak = 1'b1;
    end
  end

  always_comb begin
    void_upd = '0;
    void_upd[ev_ep] = is_out;
  end

  // ---------------------------------------------------------------
  // per-endpoint status cells
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
      rx_ep_status_cell u_cell (
        .mclk(mclk),
        .rst_n(rst_n),
        .is_ctrl(ep_ctrl[gi]),
        .ev_setup(ep_hit[gi] && tok_valid && tok_kind == TOK_SETUP),
        .ev_out_ack(ep_hit[gi] && out_ack_sent),
        .ev_hs_start(ep_hit[gi] && setup_hs_start),
        .ev_hs_end(ep_hit[gi] && setup_hs_end),
        .ev_rx_end(ep_hit[gi] && rx_end),
        .rx_ok(rx_ok),
        .ev_void_upd(void_upd[gi]),
        .void_val(dec_nak || dec_stall),
        .fw_wr(fw_hit[gi]),
        .fw_wdata(reg_wdata),
        .status(status_bus[gi]),
        .fifo_lock(rx_fifo_lock[gi]),
        .fifo_clear(rx_fifo_clear[gi])
      );
      assign rx_data_toggle[gi] = status_bus[gi][`ST_TOGGLE_BIT];
      assign setup_received_flag[gi] = status_bus[gi][`ST_SETUP_BIT];
    end
  endgenerate

  // ---------------------------------------------------------------
  // register bus and answer
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    st_next.resp_valid = is_in_out;
    st_next.resp_nak = is_in_out && dec_nak;
    st_next.resp_stall = is_in_out && dec_stall;
    if (reg_wr && reg_addr == `ENDPOINT_INDEX_ADDR) begin
      st_next.idx = reg_wdata[EP_W-1:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        `ENDPOINT_RX_STATUS_ADDR: begin
          st_next.rdata = cur_status;
        end
        `ENDPOINT_INDEX_ADDR: begin
          st_next.rdata = 8'(st_reg.idx);
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign resp_valid = st_reg.resp_valid;
  assign resp_nak = st_reg.resp_nak;
  assign resp_stall = st_reg.resp_stall;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_setup_tok;
    tok_valid && tok_kind == TOK_SETUP && ep_ctrl[ev_ep];
  endsequence

  sequence s_setup_tok_any;
    tok_valid && tok_kind == TOK_SETUP;
  endsequence

  a_setup_nak_prio: assert property (is_in_out && hold_nak |=>
    resp_valid && resp_nak && !resp_stall)
    else $error("setup flag did not force nak");
  a_stall_answer: assert property (is_in_out && !hold_nak && stalled |=>
    resp_valid && resp_stall && !resp_nak)
    else $error("stalled endpoint not stalled");
  a_setup_sets_flags: assert property (s_setup_tok ##1 1'b1 |->
    setup_received_flag[$past(ev_ep)] && rx_fifo_lock[$past(ev_ep)] &&
    rx_fifo_clear[$past(ev_ep)])
    else $error("setup token did not set flags");
  a_setup_toggle: assert property (s_setup_tok_any |=>
    rx_data_toggle[$past(ev_ep)] == `TOGGLE_AFTER_SETUP)
    else $error("toggle not forced after setup");
  a_lock_held: assert property (s_setup_tok ##1
    (!setup_hs_end && !reg_wr) [*2] |-> rx_fifo_lock[$past(ev_ep, 2)])
    else $error("fifo lock dropped early");
  a_start_clear: assert property (setup_hs_end && !tok_valid |=>
    !status_bus[$past(ev_ep)][`ST_START_OVW_BIT])
    else $error("start overwrite not cleared");
  a_enable_reads_zero: assert property (reg_rd &&
    reg_addr == `ENDPOINT_RX_STATUS_ADDR |=> !reg_rdata[`ST_OVW_EN_BIT])
    else $error("enable bit read as one");
  a_index_view: assert property (reg_rd && reg_addr == `ENDPOINT_RX_STATUS_ADDR |=>
    reg_rdata == $past(cur_status))
    else $error("status read not from indexed endpoint");
  a_ro_ignored: assert property (status_wr && !tok_valid && !rx_end &&
    !setup_hs_end |=> (cur_status & 8'h27) == ($past(cur_status) & 8'h27))
    else $error("read-only bits changed by write");
  a_void_record: assert property (is_out |=>
    status_bus[$past(ev_ep)][`ST_VOID_BIT] == (resp_nak || resp_stall))
    else $error("void does not match out answer");
  a_read_one_cycle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");

  // ---------------------------------------------------------------
  // answer checks
  // ---------------------------------------------------------------
  sequence s_out_tok;
    tok_valid && tok_kind == TOK_OUT;
  endsequence

  sequence s_plain_tok;
    is_in_out && !hold_nak && !stalled;
  endsequence

  a_resp_on_token: assert property (is_in_out |=> resp_valid)
    else $error("no answer after in or out token");

  a_resp_quiet: assert property (!is_in_out |=>
    !resp_valid && !resp_nak && !resp_stall)
    else $error("answer without in or out token");

  a_refused_nak: assert property (s_plain_tok ##0 out_refused |=>
    resp_nak && !resp_stall)
    else $error("refused out not answered with nak");

  a_plain_proceed: assert property (s_plain_tok ##0 !out_refused |=>
    !resp_nak && !resp_stall)
    else $error("free endpoint not allowed to proceed");

  a_void_on_setup: assert property (s_out_tok ##0 hold_nak |=>
    status_bus[$past(ev_ep)][`ST_VOID_BIT] && resp_nak)
    else $error("out during setup hold not void");

  a_void_quiet: assert property (!is_out && !reg_wr |=>
    $stable(cur_status[`ST_VOID_BIT]))
    else $error("void changed without out token");

  // ---------------------------------------------------------------
  // flag and lock checks
  // ---------------------------------------------------------------
  sequence s_setup_clear_gap;
    s_setup_tok ##1 !(tok_valid && tok_kind == TOK_SETUP);
  endsequence

  a_clear_pulse: assert property (s_setup_clear_gap |=>
    !rx_fifo_clear[$past(ev_ep, 2)])
    else $error("fifo clear longer than one cycle");

  a_ctrl_only_ovw: assert property (s_setup_tok_any ##0
    (!ep_ctrl[ev_ep] && !rx_fifo_lock[ev_ep]) |=>
    !rx_fifo_lock[$past(ev_ep)] && !rx_fifo_clear[$past(ev_ep)])
    else $error("overwrite flags set on non-control endpoint");

  a_setup_any_flag: assert property (s_setup_tok_any |=>
    setup_received_flag[$past(ev_ep)])
    else $error("setup flag not set by setup token");

  a_end_holds: assert property (cur_status[`ST_END_OVW_BIT] && !reg_wr |=>
    cur_status[`ST_END_OVW_BIT] && rx_fifo_lock[$past(st_reg.idx)])
    else $error("end overwrite dropped without write");

  a_setup_holds: assert property (cur_status[`ST_SETUP_BIT] && !reg_wr |=>
    cur_status[`ST_SETUP_BIT])
    else $error("setup flag dropped without write");

  a_lock_view: assert property (rx_fifo_lock[st_reg.idx] ==
    (cur_status[`ST_START_OVW_BIT] || cur_status[`ST_END_OVW_BIT]))
    else $error("fifo lock differs from overwrite flags");

  a_fw_clears_setup: assert property (status_wr && !reg_wdata[`ST_SETUP_BIT] &&
    !tok_valid |=> !cur_status[`ST_SETUP_BIT])
    else $error("setup flag not cleared by write");

  a_fw_clears_end: assert property (status_wr && !reg_wdata[`ST_END_OVW_BIT] &&
    !setup_hs_start |=> !cur_status[`ST_END_OVW_BIT])
    else $error("end overwrite not cleared by write");

  // ---------------------------------------------------------------
  // toggle and register view checks
  // ---------------------------------------------------------------
  a_fw_toggle: assert property (status_wr && reg_wdata[`ST_OVW_EN_BIT] &&
    !tok_valid && !out_ack_sent |=>
    rx_data_toggle[$past(st_reg.idx)] == $past(reg_wdata[`ST_TOGGLE_BIT]))
    else $error("enabled toggle write not taken");

  a_toggle_quiet: assert property (!tok_valid && !out_ack_sent && !status_wr |=>
    $stable(rx_data_toggle))
    else $error("toggle changed without event");

  a_ackerr_quiet: assert property (!rx_end && !reg_wr |=>
    $stable(cur_status & 8'h03))
    else $error("ack or error changed without reception end");

  a_index_read: assert property (reg_rd && reg_addr == `ENDPOINT_INDEX_ADDR |=>
    reg_rdata == 8'($past(st_reg.idx)))
    else $error("index read does not match index");

  a_unmapped_read: assert property (reg_rd && reg_addr != `ENDPOINT_RX_STATUS_ADDR &&
    reg_addr != `ENDPOINT_INDEX_ADDR |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

endmodule

/* rtl/usb_rx_status_defs.svh */
`ifndef USB_RX_STATUS_DEFS_SVH
`define USB_RX_STATUS_DEFS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ENDPOINT_RX_STATUS_ADDR 8'h0d
`define ENDPOINT_INDEX_ADDR 8'h0f

// ---------------------------------------------------------------
// status field positions
// ---------------------------------------------------------------
`define ST_TOGGLE_BIT 7
`define ST_SETUP_BIT 6
`define ST_START_OVW_BIT 5
`define ST_END_OVW_BIT 4
`define ST_OVW_EN_BIT 3
`define ST_VOID_BIT 2
`define ST_ERR_BIT 1
`define ST_ACK_BIT 0

// ---------------------------------------------------------------
// reset and forced values
// ---------------------------------------------------------------
`define RX_STATUS_RESET 8'h00
`define INDEX_RESET 4'h0
`define TOGGLE_AFTER_SETUP 1'b1

`endif

/* rtl/usb_rx_status_pkg.sv */
package usb_rx_status_pkg;

  // ---------------------------------------------------------------
  // token kinds from the serial engine
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TOK_OUT,
    TOK_IN,
    TOK_SETUP,
    TOK_NONE
  } token_kind_t;

  // ---------------------------------------------------------------
  // per-endpoint state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic toggle;
    logic setup;
    logic start_ovw;
    logic end_ovw;
    logic void_f;
    logic err;
    logic ack;
    logic lock;
    logic clear;
  } ep_state_t;

endpackage
